// [hdl/dpt_cfg.svh]
// Purpose: constants of the dual 8-bit programmable timer
// Assumes: register indices are word indices, byte address = index * 4
// Notes:   definitions only
`ifndef DPT_CFG_SVH
`define DPT_CFG_SVH
// ****************************************
// register indices
// ****************************************
`define DPT_IDX_MODE      16'hFFC0
`define DPT_IDX_OUTCLK    16'hFFC1
`define DPT_IDX_T0CTL     16'hFFC2
`define DPT_IDX_T1CTL     16'hFFC3
`define DPT_IDX_RLD0_LO   16'hFFC4
`define DPT_IDX_RLD0_HI   16'hFFC5
`define DPT_IDX_RLD1_LO   16'hFFC6
`define DPT_IDX_RLD1_HI   16'hFFC7
`define DPT_IDX_CNT0_LO   16'hFFC8
`define DPT_IDX_CNT0_HI   16'hFFC9
`define DPT_IDX_CNT1_LO   16'hFFCA
`define DPT_IDX_CNT1_HI   16'hFFCB
`define DPT_IDX_IRQEN     16'hFFE2
`define DPT_IDX_IRQPEND   16'hFFF2
// ****************************************
// field positions
// ****************************************
`define DPT_BIT_CASCADE   3
`define DPT_BIT_EVENT     2
`define DPT_BIT_FILTER    1
`define DPT_BIT_POL       0
`define DPT_BIT_OUTPUT_CHANNEL_SELECT     3
`define DPT_BIT_OUTEN     2
`define DPT_BIT_T1SRC     1
`define DPT_BIT_T0SRC     0
`define DPT_BIT_DIVHI     3
`define DPT_BIT_DIVLO     2
`define DPT_BIT_RELOAD    1
`define DPT_BIT_RUN       0
// ****************************************
// reset values and counts
// ****************************************
`define DPT_RST_NIB       4'h0
`define DPT_RST_BYTE      8'h00
`define DPT_FILTER_EDGES  2'h2
`endif

// [hdl/dpt_pkg.sv]
// Purpose: types of the dual 8-bit programmable timer
// Assumes: nothing
// Notes:   no constants here, see dpt_cfg.svh
package dpt_pkg;
  typedef enum logic [3:0] {
    DPT_DIV_1   = 4'h1,
    DPT_DIV_4   = 4'h2,
    DPT_DIV_32  = 4'h4,
    DPT_DIV_256 = 4'h8
  } dpt_div_type;
endpackage

// [hdl/dpt_timer.sv]
// Purpose: dual 8-bit down counting timer with cascade, event input and square output
// Assumes: oscillator, strobe and event inputs synchronous to core_clk_i
// Notes:   APB slave, no wait states; pready is high in the first access cycle
//
// Functional notes
// - source select bit picks slow (0) or fast (1) clock per timer.
// - in event mode timer 0 ignores source select and divider.
// - event mode bit 1 counts input edges, 0 counts prescaled pulses.
// - width bit 0 gives two timers, 1 gives one 16-bit counter.
// - cascaded: clock enters timer 0, interrupt comes from timer 1.
// - filter on: input level accepted at second 2048 Hz strobe fall.
// - filter off counts input directly; filter matters only in event mode.
// - polarity 0 counts falling input edges, 1 counts rising edges.
// - reload value loads on reload bit write and on underflow; cascaded timer 0 takes FF while timer 1 is nonzero.
// - reading low count nibble captures high nibble for the next read.
// - count locations are read-only; writes ignored.
// - forced reload resumes at once when running, held when stopped.
// - reload bit acts on 1 only, reads 0.
// - run bit 1 starts, 0 stops, except timer 1 while cascaded, which counts on every borrow; stopped counter holds its value.
// - channel select picks timer for square output; cascade forces timer 1.
// - output enable drives square wave on pin, else pin high.
// - per timer enable lets pending flag raise interrupt request.
// - pending flag set on each underflow regardless of mask, except timer 0 underflows while cascaded.
// - writing 1 clears pending flag; 0 leaves it; read shows it.
// - reset clears counters, reloads and all control bits.
// - square output toggles once per selected underflow.
// - run changes act at next input clock tick; run reads 1 until halted.
// - decrement and underflow on input clock tick; reload at same tick.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "dpt_cfg.svh"
`default_nettype none
module dpt_timer #(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // clock and event inputs
  input  wire logic              slow_oscillator_clock_i,
  input  wire logic              fast_oscillator_clock_i,
  input  wire logic              strobe_2048_i,
  input  wire logic              event_clock_input_i,
  // outputs
  output logic                   shared_output_pin_o,
  output logic [1:0]             timer_irq_req_o
);
  // ****************************************
  // register state
  // ****************************************
  logic [3:0] mode_r, outclk_r, irqen_r;
  logic [1:0] div_r [2];
  logic [1:0] run_req_r, run_act_r, pend_r;
  logic [7:0] rld0_r, rld1_r, cnt0_r, cnt1_r;
  logic [3:0] hold0_r, hold1_r;
  logic       sq_r;
  logic [31:0] prdata_r;
  logic        pready_r, pslverr_r, pin_r;
  logic [1:0]  irq_r;

  // ****************************************
  // apb decode
  // ****************************************
  wire logic        setup_w  = psel_i & ~penable_i;
  wire logic        access_w = psel_i & penable_i & pready_r;
  wire logic        wr_w     = access_w & pwrite_i;
  // read side effects land at setup, the edge that latches prdata, so both nibbles see one count
  wire logic        rd_w     = setup_w & ~pwrite_i;
  wire logic [15:0] idx_w    = paddr_i[17:2];
  wire logic        align_w  = (paddr_i[1:0] == 2'h0);
  wire logic        s_mode   = align_w & (idx_w == `DPT_IDX_MODE);
  wire logic        s_outclk = align_w & (idx_w == `DPT_IDX_OUTCLK);
  wire logic        s_t0ctl  = align_w & (idx_w == `DPT_IDX_T0CTL);
  wire logic        s_t1ctl  = align_w & (idx_w == `DPT_IDX_T1CTL);
  wire logic        s_r0lo   = align_w & (idx_w == `DPT_IDX_RLD0_LO);
  wire logic        s_r0hi   = align_w & (idx_w == `DPT_IDX_RLD0_HI);
  wire logic        s_r1lo   = align_w & (idx_w == `DPT_IDX_RLD1_LO);
  wire logic        s_r1hi   = align_w & (idx_w == `DPT_IDX_RLD1_HI);
  wire logic        s_c0lo   = align_w & (idx_w == `DPT_IDX_CNT0_LO);
  wire logic        s_c0hi   = align_w & (idx_w == `DPT_IDX_CNT0_HI);
  wire logic        s_c1lo   = align_w & (idx_w == `DPT_IDX_CNT1_LO);
  wire logic        s_c1hi   = align_w & (idx_w == `DPT_IDX_CNT1_HI);
  wire logic        s_irqen  = align_w & (idx_w == `DPT_IDX_IRQEN);
  wire logic        s_pend   = align_w & (idx_w == `DPT_IDX_IRQPEND);
  wire logic        mapped_w = s_mode | s_outclk | s_t0ctl | s_t1ctl | s_r0lo | s_r0hi | s_r1lo | s_r1hi
                             | s_c0lo | s_c0hi | s_c1lo | s_c1hi | s_irqen | s_pend;
  wire logic [3:0]  wnib_w   = pwdata_i[3:0];
  wire logic [1:0]  force_w  = {wr_w & s_t1ctl & wnib_w[`DPT_BIT_RELOAD],
                                wr_w & s_t0ctl & wnib_w[`DPT_BIT_RELOAD]};
  wire logic [1:0]  pclr_w   = (wr_w & s_pend) ? wnib_w[1:0] : 2'h0;

  // mode fields
  wire logic cascade_w = mode_r[`DPT_BIT_CASCADE];
  wire logic event_w   = mode_r[`DPT_BIT_EVENT];
  wire logic filter_w  = mode_r[`DPT_BIT_FILTER];
  wire logic pol_w     = mode_r[`DPT_BIT_POL];
  wire logic [1:0] src_sel_w = {outclk_r[`DPT_BIT_T1SRC], outclk_r[`DPT_BIT_T0SRC]};

  // read mux; the reload bit and the unused pending bits read as zero
  wire logic [3:0] ctl0_rd_w = {div_r[0], 1'b0, run_req_r[0] | run_act_r[0]};
  wire logic [3:0] ctl1_rd_w = {div_r[1], 1'b0, run_req_r[1] | run_act_r[1]};
  wire logic [3:0] rnib_w =
      s_mode   ? mode_r       : s_outclk ? outclk_r     :
      s_t0ctl  ? ctl0_rd_w    : s_t1ctl  ? ctl1_rd_w    :
      s_r0lo   ? rld0_r[3:0]  : s_r0hi   ? rld0_r[7:4]  :
      s_r1lo   ? rld1_r[3:0]  : s_r1hi   ? rld1_r[7:4]  :
      s_c0lo   ? cnt0_r[3:0]  : s_c0hi   ? hold0_r      :
      s_c1lo   ? cnt1_r[3:0]  : s_c1hi   ? hold1_r      :
      s_irqen  ? irqen_r      : s_pend   ? {2'h0, pend_r} : 4'h0;

  // ****************************************
  // event input, filter and edge select
  // ****************************************
  logic       ev_raw_r, ev_filt_r, ev_prev_r, strobe_prev_r;
  logic [1:0] filt_cnt_r;
  wire logic  strobe_fall_w = strobe_prev_r & ~strobe_2048_i;
  wire logic  ev_lvl_w      = filter_w ? ev_filt_r : ev_raw_r;
  wire logic  ev_edge_w     = pol_w ? (~ev_prev_r & ev_lvl_w) : (ev_prev_r & ~ev_lvl_w);
  wire logic [1:0] filt_cnt_nxt = (ev_raw_r == ev_filt_r) ? 2'h0 :
                                  strobe_fall_w ? (filt_cnt_r + 2'h1) : filt_cnt_r;
  wire logic  filt_take_w = (filt_cnt_nxt == `DPT_FILTER_EDGES);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_raw_r      <= 1'b0;
      ev_filt_r     <= 1'b0;
      ev_prev_r     <= 1'b0;
      strobe_prev_r <= 1'b0;
      filt_cnt_r    <= 2'h0;
    end else begin
      ev_raw_r      <= event_clock_input_i;
      ev_filt_r     <= filt_take_w ? ev_raw_r : ev_filt_r;
      filt_cnt_r    <= filt_take_w ? 2'h0 : filt_cnt_nxt;
      ev_prev_r     <= ev_lvl_w;
      strobe_prev_r <= strobe_2048_i;
    end
  end

  // ****************************************
  // prescalers and run synchronisation
  // ****************************************
  // run changes only land on an input clock tick, so a stop never cuts a count short
  logic [1:0] src_prev_r, pre_tick_w, tick_w;
  wire logic [1:0] src_lvl_w = {src_sel_w[1] ? fast_oscillator_clock_i : slow_oscillator_clock_i,
                                src_sel_w[0] ? fast_oscillator_clock_i : slow_oscillator_clock_i};
  wire logic [1:0] src_fall_w = src_prev_r & ~src_lvl_w;
  wire logic       borrow_w;
  assign tick_w[0] = event_w ? ev_edge_w : pre_tick_w[0];
  assign tick_w[1] = cascade_w ? borrow_w : pre_tick_w[1];

  for (genvar i = 0; i < 2; i++) begin : g_pre
    logic [7:0] presc_r;
    dpt_pkg::dpt_div_type div_w;
    wire logic active_w = run_req_r[i] | run_act_r[i];
    assign div_w = (div_r[i] == 2'h0) ? dpt_pkg::DPT_DIV_1  :
                   (div_r[i] == 2'h1) ? dpt_pkg::DPT_DIV_4  :
                   (div_r[i] == 2'h2) ? dpt_pkg::DPT_DIV_32 : dpt_pkg::DPT_DIV_256;
    wire logic match_w = (div_w == dpt_pkg::DPT_DIV_1)  ? 1'b1 :
                         (div_w == dpt_pkg::DPT_DIV_4)  ? (presc_r[1:0] == 2'h3) :
                         (div_w == dpt_pkg::DPT_DIV_32) ? (presc_r[4:0] == 5'h1F) :
                         (presc_r == 8'hFF);
    assign pre_tick_w[i] = src_fall_w[i] & active_w & match_w;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
        presc_r      <= `DPT_RST_BYTE;
        src_prev_r[i] <= 1'b0;
        run_act_r[i] <= 1'b0;
      end else begin
        src_prev_r[i] <= src_lvl_w[i];
        if (force_w[i] | ~active_w) begin
          presc_r <= `DPT_RST_BYTE;
        end else if (src_fall_w[i]) begin
          presc_r <= presc_r + 8'h01;
        end
        if (tick_w[i]) begin
          run_act_r[i] <= run_req_r[i];
        end
      end
    end
  end

  // ****************************************
  // counters
  // ****************************************
  wire logic dec0_w = tick_w[0] & run_act_r[0];
  wire logic uf0_w  = dec0_w & (cnt0_r == 8'h00);
  assign borrow_w   = cascade_w & uf0_w;
  wire logic dec1_w = cascade_w ? borrow_w : (tick_w[1] & run_act_r[1]);
  wire logic uf1_w  = dec1_w & (cnt1_r == 8'h00);
  // in cascade timer 0 wraps until the whole 16-bit value has run out
  wire logic [7:0] cnt0_nxt = force_w[0] ? rld0_r :
                              uf0_w ? ((cascade_w & (cnt1_r != 8'h00)) ? 8'hFF : rld0_r) :
                              dec0_w ? (cnt0_r - 8'h01) : cnt0_r;
  wire logic [7:0] cnt1_nxt = force_w[1] ? rld1_r :
                              uf1_w ? rld1_r :
                              dec1_w ? (cnt1_r - 8'h01) : cnt1_r;
  wire logic [1:0] pset_w   = {uf1_w, uf0_w & ~cascade_w};
  wire logic sel_uf_w       = (cascade_w | outclk_r[`DPT_BIT_OUTPUT_CHANNEL_SELECT]) ? uf1_w : uf0_w;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt0_r <= `DPT_RST_BYTE;
      cnt1_r <= `DPT_RST_BYTE;
      sq_r   <= 1'b0;
      pend_r <= 2'h0;
    end else begin
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
      sq_r   <= sq_r ^ sel_uf_w;
      pend_r <= pset_w | (pend_r & ~pclr_w);
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_r    <= `DPT_RST_NIB;
      outclk_r  <= `DPT_RST_NIB;
      irqen_r   <= `DPT_RST_NIB;
      div_r[0]  <= 2'h0;
      div_r[1]  <= 2'h0;
      run_req_r <= 2'h0;
      rld0_r    <= `DPT_RST_BYTE;
      rld1_r    <= `DPT_RST_BYTE;
    end else if (wr_w) begin
      if (s_mode)   mode_r   <= wnib_w;
      if (s_outclk) outclk_r <= wnib_w;
      if (s_irqen)  irqen_r  <= wnib_w;
      if (s_t0ctl) begin
        div_r[0]     <= wnib_w[`DPT_BIT_DIVHI:`DPT_BIT_DIVLO];
        run_req_r[0] <= wnib_w[`DPT_BIT_RUN];
      end
      if (s_t1ctl) begin
        div_r[1]     <= wnib_w[`DPT_BIT_DIVHI:`DPT_BIT_DIVLO];
        run_req_r[1] <= wnib_w[`DPT_BIT_RUN];
      end
      if (s_r0lo) rld0_r[3:0] <= wnib_w;
      if (s_r0hi) rld0_r[7:4] <= wnib_w;
      if (s_r1lo) rld1_r[3:0] <= wnib_w;
      if (s_r1hi) rld1_r[7:4] <= wnib_w;
    end
  end

  // ****************************************
  // bus answer, read capture and outputs
  // ****************************************
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold0_r   <= `DPT_RST_NIB;
      hold1_r   <= `DPT_RST_NIB;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      pin_r     <= 1'b1;
      irq_r     <= 2'h0;
    end else begin
      if (rd_w & s_c0lo) hold0_r <= cnt0_r[7:4];
      if (rd_w & s_c1lo) hold1_r <= cnt1_r[7:4];
      prdata_r  <= setup_w ? {28'h0, rnib_w} : prdata_r;
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~mapped_w;
      pin_r     <= outclk_r[`DPT_BIT_OUTEN] ? sq_r : 1'b1;
      irq_r     <= pend_r & irqen_r[1:0];
    end
  end

  assign prdata_o            = prdata_r;
  assign pready_o            = pready_r;
  assign pslverr_o           = pslverr_r;
  assign shared_output_pin_o = pin_r;
  assign timer_irq_req_o     = irq_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_reload_reads_zero: assert property (pready_r && (s_t0ctl || s_t1ctl) |-> !prdata_r[1])
    else $error("reload bit read as one");
  a_pend_on_under: assert property (uf0_w && !cascade_w |=> pend_r[0])
    else $error("pending flag missed an underflow");
  a_pend_clear: assert property (pclr_w[1] && !pset_w[1] |=> !pend_r[1])
    else $error("pending flag not cleared by written one");
  a_count_ro: assert property (wr_w && s_c0lo && !dec0_w && !force_w[0] |=> $stable(cnt0_r))
    else $error("write disturbed the counter");
  a_square_toggle: assert property (sel_uf_w |=> sq_r != $past(sq_r))
    else $error("square output did not toggle");
  a_pin_idle_high: assert property (!outclk_r[`DPT_BIT_OUTEN] |=> shared_output_pin_o)
    else $error("pin not high while output disabled");
  a_irq_masked: assert property (##1 timer_irq_req_o == ($past(pend_r) & $past(irqen_r[1:0])))
    else $error("interrupt request does not follow mask");
  a_stop_holds: assert property (!run_act_r[0] && !force_w[0] && !cascade_w |=> $stable(cnt0_r))
    else $error("stopped counter changed");
  a_event_only_edges: assert property (event_w && !ev_edge_w && !force_w[0] |=> $stable(cnt0_r))
    else $error("event counter moved without an edge");
  a_hold_capture: assert property (rd_w && s_c0lo |=> hold0_r == $past(cnt0_r[7:4]))
    else $error("high nibble not captured");
  a_reload_on_under: assert property (uf1_w && !force_w[1] |=> cnt1_r == $past(rld1_r))
    else $error("underflow did not reload");
  a_force_loads: assert property (force_w[0] |=> cnt0_r == $past(rld0_r))
    else $error("forced reload did not load the counter");
  a_stop_waits_tick: assert property (run_act_r[0] && !tick_w[0] |=> run_act_r[0])
    else $error("run state changed between input ticks");
  a_start_on_tick: assert property (run_req_r[0] && tick_w[0] |=> run_act_r[0])
    else $error("run request not taken at input tick");
  a_cascade_no_pend0: assert property (cascade_w && !pend_r[0] |=> !pend_r[0])
    else $error("timer 0 flag set while cascaded");
  a_unselected_silent: assert property (outclk_r[`DPT_BIT_OUTPUT_CHANNEL_SELECT] && uf0_w && !uf1_w |=> $stable(sq_r))
    else $error("square output followed the unselected timer");
  a_dec_by_one: assert property (dec0_w && !uf0_w && !force_w[0] |=> cnt0_r == $past(cnt0_r) - 8'h01)
    else $error("counter did not step down by one");
  a_cascade_reload: assert property (cascade_w && uf0_w && (cnt1_r == 8'h00) && !force_w[0] |=> cnt0_r == $past(rld0_r))
    else $error("cascaded underflow did not reload timer 0");
  a_filter_waits: assert property ((filt_cnt_r == 2'h0) && !strobe_fall_w |=> $stable(ev_filt_r))
    else $error("filter accepted a level too early");
  a_pend1_on_under: assert property (uf1_w |=> pend_r[1])
    else $error("timer 1 flag missed an underflow");
  a_pin_follows_sq: assert property (outclk_r[`DPT_BIT_OUTEN] |=> shared_output_pin_o == $past(sq_r))
    else $error("pin does not carry the square output");

  // ****************************************
  // cover points
  // ****************************************

  c_cascade_under: cover property (cascade_w && uf1_w);
  c_event_count: cover property (event_w && dec0_w);
  c_filter_take: cover property (filter_w && filt_take_w);
  c_stop_taken: cover property (run_act_r[0] && !run_req_r[0] ##1 !run_act_r[0]);
  c_irq_raised: cover property (timer_irq_req_o[0]);
endmodule
`default_nettype wire

// [verif/dpt_event_source.sv]
// Purpose: far-side model driving the timer event count input
// Assumes: called just after a rising edge of core_clk_i
// Notes:   the line is always driven and idles low
`timescale 1ns/100ps
`default_nettype none
module dpt_event_source (
  // clock
  input  wire logic core_clk_i,
  // event line
  output var logic  event_o
);
  initial event_o = 1'h0;
  // high for hi_cyc cycles, then a long low so a filtered input settles too
  task automatic pulse(input int hi_cyc);
    event_o <= 1'h1;
    repeat (hi_cyc) @(posedge core_clk_i);
    event_o <= 1'h0;
    repeat (40) @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: self-checking bench for the dual 8-bit programmable timer
// Assumes: zero wait state apb slave, source levels derived from core_clk_i
// Notes:   fast source period 2 cycles, slow 16, filter strobe 8
`timescale 1ns/100ps
`include "dpt_cfg.svh"
`default_nettype none
module tb_top;
  // ****************************************
  // signals and instances
  // ****************************************
  logic        core_clk_i;
  logic        reset_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [17:0] paddr_i;
  logic [31:0] pwdata_i;
  wire  logic [31:0] prdata_o;
  wire  logic        pready_o;
  wire  logic        pslverr_o;
  wire  logic        event_i;
  wire  logic        pin_o;
  wire  logic [1:0]  irq_o;
  logic [7:0]  osc_r = 8'h00;
  int          err_total = 0;
  int          checked = 0;
  always @(posedge core_clk_i) osc_r <= osc_r + 8'h01;
  dpt_timer #(.ADDR_W(18)) dpt_timer_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .slow_oscillator_clock_i(osc_r[3]),
    .fast_oscillator_clock_i(osc_r[0]), .strobe_2048_i(osc_r[2]),
    .event_clock_input_i(event_i), .shared_output_pin_o(pin_o), .timer_irq_req_o(irq_o));
  dpt_event_source dpt_event_source_inst (.core_clk_i(core_clk_i), .event_o(event_i));
  initial begin
    core_clk_i = 1'h0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic timeout;
    err_total++;
    $display("BAD t=%0t wait ran out", $time);
    end_sim();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after a rising edge; results taken at the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [3:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel_i   <= 1'h1;
    pwrite_i <= wr;
    paddr_i  <= {idx, 2'h0};
    pwdata_i <= {28'h0, wd};
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge core_clk_i);
      n++;
      if (n > 20) timeout();
    end while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'h0;
    penable_i <= 1'h0;
    // idle cycle so psel is never assigned twice in one step
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [3:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, idx, d, r, e);
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'h0, idx, 4'h0, r, e);
    check(r, exp);
    check({31'h0, e}, 32'h0);
  endtask
  // low nibble first: that read captures the high nibble
  task automatic rd8(input logic [15:0] idx, output logic [7:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'h0, idx, 4'h0, r, e);
    v[3:0] = r[3:0];
    apb(1'h0, idx + 16'h1, 4'h0, r, e);
    v[7:4] = r[3:0];
  endtask
  task automatic toggle_gap(output int gap);
    logic last;
    @(negedge core_clk_i);
    for (int k = 0; k < 2; k++) begin
      last = pin_o;
      gap = 0;
      do begin
        @(negedge core_clk_i);
        gap++;
        if (gap > 5000) timeout();
      end while (pin_o === last);
    end
    @(posedge core_clk_i);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset;
    logic [15:0] idx [10];
    logic [31:0] r;
    logic        e;
    idx = '{`DPT_IDX_MODE, `DPT_IDX_OUTCLK, `DPT_IDX_T0CTL, `DPT_IDX_T1CTL, `DPT_IDX_RLD0_LO,
            `DPT_IDX_RLD1_HI, `DPT_IDX_CNT0_LO, `DPT_IDX_CNT1_HI, `DPT_IDX_IRQEN, `DPT_IDX_IRQPEND};
    foreach (idx[i]) rd_chk(idx[i], 32'h0);
    apb(1'h0, 16'hFFD0, 4'h0, r, e);
    check({r[30:0], e}, 32'h1);
    check({31'h0, pin_o}, 32'h1);
  endtask
  task automatic s_div;
    int gap;
    int ratio [4];
    logic last;
    ratio = '{1, 4, 32, 256};
    for (int d = 0; d < 5; d++) begin
      wr(`DPT_IDX_OUTCLK, {2'h1, 1'h0, d != 4});
      wr(`DPT_IDX_T0CTL, {d == 4 ? 2'h1 : 2'(d), 2'h1});
      toggle_gap(gap);
      check(gap, ratio[d == 4 ? 1 : d] * (d == 4 ? 16 : 2));
    end
    // timer 1 idle, so choosing it must freeze the square output
    wr(`DPT_IDX_OUTCLK, 4'hC);
    // let a toggle launched before the switch reach the pin first
    @(negedge core_clk_i);
    last = pin_o;
    repeat (600) @(posedge core_clk_i);
    check({31'h0, pin_o}, {31'h0, last});
  endtask
  task automatic s_irq;
    int n;
    wr(`DPT_IDX_T0CTL, 4'h0);
    repeat (100) @(posedge core_clk_i);
    rd_chk(`DPT_IDX_IRQPEND, 32'h1);
    check({30'h0, irq_o}, 32'h0);
    wr(`DPT_IDX_IRQPEND, 4'h0);
    rd_chk(`DPT_IDX_IRQPEND, 32'h1);
    wr(`DPT_IDX_IRQPEND, 4'h1);
    rd_chk(`DPT_IDX_IRQPEND, 32'h0);
    wr(`DPT_IDX_IRQEN, 4'h1);
    wr(`DPT_IDX_T0CTL, 4'h5);
    for (n = 0; n < 300 && irq_o !== 2'h1; n++) @(negedge core_clk_i);
    check({30'h0, irq_o}, 32'h1);
    @(posedge core_clk_i);
    wr(`DPT_IDX_T0CTL, 4'h0);
    repeat (100) @(posedge core_clk_i);
    wr(`DPT_IDX_IRQPEND, 4'h1);
    wr(`DPT_IDX_IRQEN, 4'h0);
  endtask
  task automatic s_reload;
    logic [7:0] v;
    wr(`DPT_IDX_RLD0_LO, 4'h5);
    wr(`DPT_IDX_RLD0_HI, 4'h3);
    wr(`DPT_IDX_T0CTL, 4'h2);
    rd_chk(`DPT_IDX_T0CTL, 32'h0);
    rd8(`DPT_IDX_CNT0_LO, v);
    check({24'h0, v}, 32'h35);
    wr(`DPT_IDX_CNT0_LO, 4'hA);
    wr(`DPT_IDX_CNT0_HI, 4'hA);
    rd8(`DPT_IDX_CNT0_LO, v);
    check({24'h0, v}, 32'h35);
  endtask
  task automatic s_stop;
    logic [7:0] v1;
    logic [7:0] v2;
    wr(`DPT_IDX_RLD0_LO, 4'h0);
    wr(`DPT_IDX_RLD0_HI, 4'h8);
    wr(`DPT_IDX_OUTCLK, 4'h0);
    wr(`DPT_IDX_T0CTL, 4'h7);
    repeat (300) @(posedge core_clk_i);
    wr(`DPT_IDX_T0CTL, 4'h4);
    repeat (100) @(posedge core_clk_i);
    rd8(`DPT_IDX_CNT0_LO, v1);
    repeat (200) @(posedge core_clk_i);
    rd8(`DPT_IDX_CNT0_LO, v2);
    check({24'h0, v2}, {24'h0, v1});
    check({31'h0, v1 < 8'h80}, 32'h1);
    wr(`DPT_IDX_T0CTL, 4'h5);
    repeat (300) @(posedge core_clk_i);
    rd8(`DPT_IDX_CNT0_LO, v2);
    check({31'h0, v2 < v1}, 32'h1);
    wr(`DPT_IDX_T0CTL, 4'h0);
    repeat (100) @(posedge core_clk_i);
  endtask
  task automatic s_event;
    logic [7:0] v;
    wr(`DPT_IDX_MODE, 4'h4);
    wr(`DPT_IDX_OUTCLK, 4'h1);
    wr(`DPT_IDX_RLD0_LO, 4'h5);
    wr(`DPT_IDX_RLD0_HI, 4'h0);
    wr(`DPT_IDX_T0CTL, 4'hF);
    repeat (3) dpt_event_source_inst.pulse(4);
    rd8(`DPT_IDX_CNT0_LO, v);
    check({24'h0, v}, 32'h3);
    wr(`DPT_IDX_MODE, 4'h5);
    repeat (2) dpt_event_source_inst.pulse(4);
    rd8(`DPT_IDX_CNT0_LO, v);
    check({24'h0, v}, 32'h1);
    wr(`DPT_IDX_MODE, 4'h6);
    dpt_event_source_inst.pulse(2);
    rd8(`DPT_IDX_CNT0_LO, v);
    check({24'h0, v}, 32'h1);
    dpt_event_source_inst.pulse(40);
    rd8(`DPT_IDX_CNT0_LO, v);
    check({24'h0, v}, 32'h0);
    wr(`DPT_IDX_T0CTL, 4'h0);
  endtask
  task automatic s_cascade;
    logic [31:0] r;
    logic        e;
    int          gap;
    r = 32'h0;
    wr(`DPT_IDX_MODE, 4'h8);
    wr(`DPT_IDX_RLD0_LO, 4'h1);
    wr(`DPT_IDX_RLD1_LO, 4'h0);
    wr(`DPT_IDX_OUTCLK, 4'h5);
    wr(`DPT_IDX_T1CTL, 4'h2);
    // drop flags left by the last tick of the previous scenario
    wr(`DPT_IDX_IRQPEND, 4'h3);
    wr(`DPT_IDX_T0CTL, 4'h3);
    for (int k = 0; k < 40 && r == 32'h0; k++) apb(1'h0, `DPT_IDX_IRQPEND, 4'h0, r, e);
    check(r, 32'h2);
    toggle_gap(gap);
    check(gap, 4);
  endtask
  initial begin
    reset_i   = 1'h1;
    psel_i    = 1'h0;
    penable_i = 1'h0;
    pwrite_i  = 1'h0;
    paddr_i   = 18'h0;
    pwdata_i  = 32'h0;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'h0;
    @(posedge core_clk_i);
    s_reset();
    s_div();
    s_irq();
    s_reload();
    s_stop();
    s_event();
    s_cascade();
    end_sim();
  end
endmodule
`default_nettype wire
